// ===== logic/deep_sleep_cfg.svh
// offsets, field positions, reset values and keys of the deep sleep control block
// Contract
// - select set: wait enters deep sleep, else sleep
// - select hardware cleared; reset value from configuration
// - retention bit keeps upper retained words through sleep
// - word zero always keeps its contents
// - access needs unlock; each write done twice
// - calendar disable bit turns calendar clock off
// - clock wake disable blocks alarm wake-up
// - external wake disable ignores change notification
// - brownout status set in deep sleep when enabled and supply low
// - brownout only sets status, never wakes
// - pin hold keeps pins frozen after wake
// - change notification in deep sleep sets flag
// - fault in deep sleep sets fault flag
// - watchdog timeout in deep sleep sets flag
// - calendar alarm in deep sleep sets flag
// - active asserted reset pin in deep sleep sets its flag
// - setting select clears all wake flags
// - unimplemented bits read as zero
`ifndef DEEP_SLEEP_CFG_SVH
`define DEEP_SLEEP_CFG_SVH

`define ADDR_W 16
`define OFS_CTL 16'h0040
`define OFS_WAKE 16'h0044
`define OFS_WORD0 16'h0048
`define OFS_KEY 16'h004c
`define OFS_WORD27 16'h8a00
`define OFS_WORD28 16'h00ac
`define OFS_WORD29 16'h00b0
`define OFS_WORD30 16'h00b4
`define OFS_WORD31 16'h00b8
`define OFS_WORD32 16'h00bc

`define CTL_SEL 15
`define CTL_RET 13
`define CTL_CALDIS 12
`define CTL_CWDIS 8
`define CTL_EXTDIS 2
`define CTL_BOR 1
`define CTL_HOLD 0
`define CTL_MASK 32'h0000b107

`define WAKE_CN 8
`define WAKE_FLT 7
`define WAKE_WDT 4
`define WAKE_ALM 3
`define WAKE_RST 2
`define WAKE_MASK 32'h0000019c

`define CTL_RESET 32'h00000000
`define WAKE_RESET 32'h00000000
`define WORD_RESET 32'h00000000
`define WORDS 7
// unlock keys are arbitrary values
`define KEY_FIRST 32'h5a5a0001
`define KEY_SECOND 32'ha5a50002

`endif

// ===== logic/deep_sleep_pkg.sv
// types shared by the deep sleep control block
package deep_sleep_pkg;

	typedef enum logic [1:0] {st_run, st_sleep, st_deep} power_state_e;

	// asynchronous event and strap levels from outside the clock domain
	typedef struct packed {
		logic cfg_deep;
		logic brownout_detect_enable;
		logic brownout;
		logic reset_pin_active;
		logic master_reset_pin;
		logic calendar_alarm;
		logic watchdog_timeout;
		logic fault;
		logic change_notify;
	} event_s;

	typedef struct packed {
		logic ctl;
		logic wake;
		logic key;
		logic mem;
		logic [2:0] idx;
	} decode_s;

	typedef logic [31:0] word_t;

endpackage

// ===== logic/retain_mem.sv
// retained general purpose words with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "deep_sleep_cfg.svh"

module retain_mem
	import deep_sleep_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic we,
	input wire logic [2:0] idx,
	input wire word_t wdata,
	input wire logic clear_upper,
	output word_t rdata
);
	word_t mem_r [`WORDS];

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			for (int i = 0; i < `WORDS; i++)
				mem_r[i] <= `WORD_RESET;
			rdata <= `WORD_RESET;
		end
		else if (ce)
		begin
			// word zero never cleared; upper words lost without retention
			for (int i = 1; i < `WORDS; i++)
				if (clear_upper)
					mem_r[i] <= `WORD_RESET;
			if (we)
				mem_r[idx] <= wdata;
			rdata <= mem_r[idx];
		end
	end
endmodule // retain_mem

`default_nettype wire

// ===== logic/deep_sleep_control.sv
// deep sleep control: mode select, wake sources, retained words, Avalon-MM slave
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "deep_sleep_cfg.svh"

module deep_sleep_control
	import deep_sleep_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [`ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire word_t writedata,
	input wire logic [3:0] byteenable,
	output word_t readdata,
	output logic waitrequest,
	input wire logic wait_exec,
	input wire logic irq_wake,
	input wire event_s events,
	output logic sleep_active,
	output logic deep_sleep_active,
	output logic calendar_enable,
	output logic pins_frozen,
	output logic core_wake,
	output logic unlocked
);

	function automatic decode_s decode(input logic [`ADDR_W-1:0] a);
		decode_s d;
		d = '0;
		case (a)
			`OFS_CTL: d.ctl = 1'b1;
			`OFS_WAKE: d.wake = 1'b1;
			`OFS_KEY: d.key = 1'b1;
			`OFS_WORD0: d.mem = 1'b1;
			`OFS_WORD27: {d.mem, d.idx} = {1'b1, 3'h1};
			`OFS_WORD28: {d.mem, d.idx} = {1'b1, 3'h2};
			`OFS_WORD29: {d.mem, d.idx} = {1'b1, 3'h3};
			`OFS_WORD30: {d.mem, d.idx} = {1'b1, 3'h4};
			`OFS_WORD31: {d.mem, d.idx} = {1'b1, 3'h5};
			`OFS_WORD32: {d.mem, d.idx} = {1'b1, 3'h6};
			default: d = '0;
		endcase
		return d;
	endfunction

	function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] be);
		word_t m;
		m = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				m[b*8 +: 8] = nw[b*8 +: 8];
		return m;
	endfunction

	event_s ev_meta_r;
	event_s ev_r;
	power_state_e state_r;
	power_state_e state_nxt;
	word_t ctl_r;
	word_t ctl_nxt;
	word_t wake_r;
	word_t wake_hw;
	word_t mem_rd;
	logic busy_r;
	logic pend_r;
	logic [`ADDR_W-1:0] pend_addr_r;
	logic key_stage_r;
	logic cfg_pend_r;

	// two flops before any logic reads the outside levels
	always_ff @(posedge mclk)
	begin
		if (ce)
		begin
			ev_meta_r <= events;
			ev_r <= ev_meta_r;
		end
	end

	// bus handshake: taken, one cycle to read the memory, then answered
	wire decode_s dec = decode(address);
	wire req = read | write;
	wire done = req & ~waitrequest;
	wire wr_done = done & write;
	wire rd_load = busy_r & waitrequest & read;
	wire guarded = dec.ctl | dec.wake | dec.mem;
	wire second = pend_r & (pend_addr_r == address);
	wire guard_wr = wr_done & guarded & unlocked;
	wire commit = guard_wr & second;
	wire ctl_commit = commit & dec.ctl;
	wire wake_commit = commit & dec.wake;
	wire mem_we = commit & dec.mem;

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			busy_r <= 1'b0;
			waitrequest <= 1'b1;
		end
		else if (ce)
		begin
			busy_r <= done ? 1'b0 : (busy_r | (req & waitrequest));
			waitrequest <= done | ~busy_r;
		end
	end

	// unlock: two keys in a row; any other key write locks again
	wire key_wr = wr_done & dec.key;
	wire key1 = writedata == `KEY_FIRST;
	wire key2 = key_stage_r & (writedata == `KEY_SECOND);

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			key_stage_r <= 1'b0;
			unlocked <= 1'b0;
			pend_r <= 1'b0;
			pend_addr_r <= '0;
		end
		else if (ce)
		begin
			if (key_wr)
			begin
				key_stage_r <= key1;
				unlocked <= key2;
			end
			// first write only arms; the matching second write lands
			if (guard_wr)
				pend_r <= ~second;
			else if (wr_done)
				pend_r <= 1'b0;
			if (guard_wr)
				pend_addr_r <= address;
		end
	end

	// control register
	wire word_t ctl_wr = merge(ctl_r, writedata, byteenable) & `CTL_MASK;
	wire word_t ctl_base = ctl_commit ? ctl_wr : ctl_r;
	wire sel_rise = ctl_commit & ctl_wr[`CTL_SEL] & ~ctl_r[`CTL_SEL];
	wire in_deep = state_r == st_deep;
	wire bor_set = in_deep & ev_r.brownout & ev_r.brownout_detect_enable;
	wire ext_ok = ev_r.change_notify & ~ctl_r[`CTL_EXTDIS];
	wire alarm_ok = ev_r.calendar_alarm & ~ctl_r[`CTL_CWDIS] & ~ctl_r[`CTL_CALDIS];
	wire pin_ok = ev_r.master_reset_pin & ev_r.reset_pin_active;
	// brownout is left out on purpose: it is status only
	wire deep_wake = ext_ok | alarm_ok | ev_r.watchdog_timeout | pin_ok | ev_r.fault;
	wire deep_exit = in_deep & deep_wake;
	wire deep_entry = (state_r == st_run) & wait_exec & ctl_r[`CTL_SEL];

	always_comb
	begin
		ctl_nxt = ctl_base;
		// strap is loaded once, after reset release, when the sync is valid
		if (cfg_pend_r)
			ctl_nxt[`CTL_SEL] = ev_r.cfg_deep;
		else if (deep_exit)
			ctl_nxt[`CTL_SEL] = 1'b0;
		ctl_nxt[`CTL_BOR] = ctl_base[`CTL_BOR] | bor_set;
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			ctl_r <= `CTL_RESET;
			cfg_pend_r <= 1'b1;
		end
		else if (ce)
		begin
			ctl_r <= ctl_nxt;
			cfg_pend_r <= 1'b0;
		end
	end

	// wake source flags: hardware set wins over any clear
	always_comb
	begin
		wake_hw = '0;
		wake_hw[`WAKE_CN] = in_deep & ext_ok;
		wake_hw[`WAKE_FLT] = in_deep & ev_r.fault;
		wake_hw[`WAKE_WDT] = in_deep & ev_r.watchdog_timeout;
		wake_hw[`WAKE_ALM] = in_deep & ev_r.calendar_alarm;
		wake_hw[`WAKE_RST] = in_deep & pin_ok;
	end

	wire word_t wake_wr = merge(wake_r, writedata, byteenable);
	wire word_t wake_kept = wake_commit ? wake_wr : (sel_rise ? `WAKE_RESET : wake_r);
	wire word_t wake_nxt = (wake_kept & `WAKE_MASK) | wake_hw;

	always_ff @(posedge mclk)
	begin
		if (reset)
			wake_r <= `WAKE_RESET;
		else if (ce)
			wake_r <= wake_nxt;
	end

	// power state
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			st_run:
				if (wait_exec)
					state_nxt = ctl_r[`CTL_SEL] ? st_deep : st_sleep;
			st_sleep:
				if (irq_wake)
					state_nxt = st_run;
			st_deep:
				if (deep_wake)
					state_nxt = st_run;
		endcase
	end

	wire release_pins = (state_r == st_run) & ~ctl_r[`CTL_HOLD];

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state_r <= st_run;
			sleep_active <= 1'b0;
			deep_sleep_active <= 1'b0;
			core_wake <= 1'b0;
			calendar_enable <= 1'b1;
			pins_frozen <= 1'b0;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			sleep_active <= state_nxt == st_sleep;
			deep_sleep_active <= state_nxt == st_deep;
			core_wake <= ((state_r == st_sleep) & irq_wake) | deep_exit;
			calendar_enable <= ~ctl_nxt[`CTL_CALDIS];
			// pins stay frozen after wake until software drops the hold bit
			if (deep_entry)
				pins_frozen <= 1'b1;
			else if (release_pins)
				pins_frozen <= 1'b0;
		end
	end

	// retained words; the memory read completes the cycle before the answer
	wire word_t mem_wr = merge(mem_rd, writedata, byteenable);
	wire clear_upper = deep_exit & ~ctl_r[`CTL_RET];

	retain_mem u_mem (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.we(mem_we),
		.idx(dec.idx),
		.wdata(mem_wr),
		.clear_upper(clear_upper),
		.rdata(mem_rd)
	);

	// locked reads of guarded registers return zero
	wire word_t rd_guard = dec.ctl ? ctl_r : (dec.wake ? wake_r : mem_rd);
	wire word_t rd_key = {31'h0, unlocked};
	wire word_t rd_mux = guarded ? (unlocked ? rd_guard : '0) : (dec.key ? rd_key : '0);

	always_ff @(posedge mclk)
	begin
		if (reset)
			readdata <= '0;
		else if (ce && rd_load)
			readdata <= rd_mux;
	end
endmodule // deep_sleep_control

`default_nettype wire

// ===== testbench/deep_sleep_props.sv
// concurrent checks on the deep sleep control ports
`timescale 1ns/10ps
`default_nettype none
module deep_sleep_props
	import deep_sleep_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	input wire logic wait_exec,
	input wire logic irq_wake,
	input wire logic sleep_active,
	input wire logic deep_sleep_active,
	input wire logic pins_frozen,
	input wire logic core_wake,
	input wire logic unlocked
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	sequence req_s;
		ce && (read || write) && waitrequest;
	endsequence
	sequence run_wait_s;
		ce && wait_exec && !sleep_active && !deep_sleep_active;
	endsequence
	chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	chk_bus_answer: assert property (req_s |-> ##[1:3] !waitrequest)
		else $error("bus request unanswered");
	chk_unlock_bus: assert property ($rose(unlocked) |-> $past(write))
		else $error("unlock without write");
	chk_mode_entry: assert property (run_wait_s |=> sleep_active ^ deep_sleep_active)
		else $error("wait did not enter a sleep mode");
	chk_mode_excl: assert property (!(sleep_active && deep_sleep_active))
		else $error("both sleep modes active");
	chk_wake_pulse: assert property (core_wake |=> !core_wake)
		else $error("wake pulse too long");
	chk_deep_exit: assert property ($fell(deep_sleep_active) |-> ##[0:1] core_wake)
		else $error("deep exit without wake pulse");
	chk_freeze_entry: assert property ($rose(deep_sleep_active) |-> ##[0:1] pins_frozen)
		else $error("pins not held on deep entry");
	chk_sleep_wake: assert property (ce && sleep_active && irq_wake |-> ##[1:2] !sleep_active)
		else $error("sleep not left on wake");
endmodule // deep_sleep_props
bind deep_sleep_control deep_sleep_props deep_sleep_props_inst (.mclk(mclk), .reset(reset),
	.ce(ce), .read(read), .write(write), .waitrequest(waitrequest), .wait_exec(wait_exec),
	.irq_wake(irq_wake), .sleep_active(sleep_active), .deep_sleep_active(deep_sleep_active),
	.pins_frozen(pins_frozen), .core_wake(core_wake), .unlocked(unlocked));
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the deep sleep control block
`timescale 1ns/10ps
`default_nettype none
`include "deep_sleep_cfg.svh"
module tb_top
	import deep_sleep_pkg::*;
;
	logic mclk = 1'b0, reset = 1'b1, ce = 1'b1, read = 1'b0, write = 1'b0;
	logic wait_exec = 1'b0, irq_wake = 1'b0;
	logic [15:0] address = 16'h0000;
	logic [3:0] byteenable = 4'hf;
	word_t writedata = 32'h0, readdata, q;
	event_s events = 9'h000;
	logic waitrequest, sleep_active, deep_sleep_active, calendar_enable;
	logic pins_frozen, core_wake, unlocked;
	int failures = 0, num_checks = 0, cycles = 0;
	always #2.5 mclk = ~mclk;
	deep_sleep_control deep_sleep_control_inst (.mclk, .reset, .ce, .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest, .wait_exec, .irq_wake, .events,
		.sleep_active, .deep_sleep_active, .calendar_enable, .pins_frozen, .core_wake,
		.unlocked);
	task print_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			print_verdict;
		end
	end
	task chk(input string n, input word_t e, input word_t g);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task chkb(input string n, input logic e, input logic g);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %b got %b", n, e, g);
		end
	endtask
	// request held until waitrequest is sampled low
	task xfer(input logic w, input logic [15:0] a, input word_t d);
		@(posedge mclk);
		address <= a;
		read <= !w;
		write <= w;
		writedata <= d;
		@(posedge mclk);
		while (waitrequest !== 1'b0)
			@(posedge mclk);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task wr2(input logic [15:0] a, input word_t d);
		xfer(1'b1, a, d);
		xfer(1'b1, a, d);
	endtask
	task rd(input string n, input logic [15:0] a, input word_t e);
		xfer(1'b0, a, 32'h0);
		chk(n, e, q);
	endtask
	task pulse;
		@(posedge mclk);
		wait_exec <= 1'b1;
		@(posedge mclk);
		wait_exec <= 1'b0;
		@(posedge mclk);
	endtask
	task t_locked;
		rd("ctl", `OFS_CTL, `CTL_RESET);
		wr2(`OFS_WORD0, 32'h1111_1111);
		xfer(1'b1, `OFS_KEY, `KEY_FIRST);
		xfer(1'b1, `OFS_KEY, `KEY_SECOND);
		@(posedge mclk);
		chkb("unlocked", 1'b1, unlocked);
		xfer(1'b1, `OFS_WORD0, 32'h2222_2222);
		rd("word0", `OFS_WORD0, `WORD_RESET);
		$display("test locked done");
	endtask
	task t_ctl;
		wr2(`OFS_CTL, 32'hffff_7ffd);
		rd("ctl", `OFS_CTL, 32'h0000_3105);
		chkb("cal_en", 1'b0, calendar_enable);
		wr2(`OFS_WAKE, 32'hffff_ffff);
		rd("wake", `OFS_WAKE, `WAKE_MASK);
		wr2(`OFS_CTL, 32'h0000_8000);
		rd("wake", `OFS_WAKE, 32'h0);
		wr2(`OFS_CTL, 32'h0);
		@(posedge mclk);
		chkb("cal_en", 1'b1, calendar_enable);
		$display("test control done");
	endtask
	task t_sleep;
		pulse;
		chkb("sleep", 1'b1, sleep_active);
		chkb("deep", 1'b0, deep_sleep_active);
		irq_wake <= 1'b1;
		repeat (3) @(posedge mclk);
		irq_wake <= 1'b0;
		chkb("sleep", 1'b0, sleep_active);
		$display("test sleep done");
	endtask
	// one deep sleep round: configure, enter, wake by events, read back
	task t_deep(input word_t c, input event_s ev, input word_t ew, input word_t ec,
		input word_t e27);
		int n;
		wr2(`OFS_WORD27, 32'h1234_5678);
		wr2(`OFS_CTL, c);
		pulse;
		chkb("deep", 1'b1, deep_sleep_active);
		chkb("frozen", 1'b1, pins_frozen);
		events <= ev;
		n = 0;
		while (deep_sleep_active !== 1'b0 && n < 20)
		begin
			@(posedge mclk);
			n++;
		end
		events <= 9'h000;
		chkb("deep", 1'b0, deep_sleep_active);
		rd("wake", `OFS_WAKE, ew);
		rd("ctl", `OFS_CTL, ec);
		rd("w27", `OFS_WORD27, e27);
		rd("w0", `OFS_WORD0, 32'hcafe_f00d);
		chkb("frozen", 1'b0, pins_frozen);
		$display("test deep done");
	endtask
	// brownout and a disabled alarm leave deep sleep alone; the hold bit keeps pins
	task t_bor;
		wr2(`OFS_CTL, 32'h8101);
		pulse;
		events <= 9'h0c8;
		repeat (6) @(posedge mclk);
		chkb("deep", 1'b1, deep_sleep_active);
		events <= 9'h004;
		repeat (6) @(posedge mclk);
		chkb("deep", 1'b0, deep_sleep_active);
		events <= 9'h000;
		rd("wake", `OFS_WAKE, 32'h18);
		rd("ctl", `OFS_CTL, 32'h103);
		chkb("frozen", 1'b1, pins_frozen);
		wr2(`OFS_CTL, 32'h0);
		repeat (2) @(posedge mclk);
		chkb("frozen", 1'b0, pins_frozen);
		$display("test brownout done");
	endtask
	// clock enable low must swallow the wait pulse
	task t_freeze;
		@(posedge mclk);
		ce <= 1'b0;
		pulse;
		ce <= 1'b1;
		chkb("sleep", 1'b0, sleep_active);
		$display("test freeze done");
	endtask
	// second reset with the strap high: select bit comes from the strap
	task t_strap;
		@(posedge mclk);
		events <= 9'h100;
		reset <= 1'b1;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		xfer(1'b1, `OFS_KEY, `KEY_FIRST);
		xfer(1'b1, `OFS_KEY, `KEY_SECOND);
		rd("ctl", `OFS_CTL, 32'h8000);
		events <= 9'h000;
		$display("test strap done");
	endtask
	initial
	begin
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_locked;
		wr2(`OFS_WORD0, 32'hcafe_f00d);
		t_ctl;
		t_sleep;
		t_deep(32'ha000, 9'h004, 32'h10, 32'h2000, 32'h1234_5678);
		t_deep(32'h8000, 9'h002, 32'h80, 32'h0, 32'h0);
		t_deep(32'h8000, 9'h001, 32'h100, 32'h0, 32'h0);
		t_deep(32'h8000, 9'h008, 32'h08, 32'h0, 32'h0);
		t_deep(32'h8000, 9'h030, 32'h04, 32'h0, 32'h0);
		t_deep(32'h8004, 9'h005, 32'h10, 32'h4, 32'h0);
		t_deep(32'h8000, 9'h0c4, 32'h10, 32'h2, 32'h0);
		t_bor;
		t_freeze;
		t_strap;
		print_verdict;
	end
endmodule // tb_top
`default_nettype wire
